/* File: rtl/ar_pkg.sv */
// Types shared by the auto-reclose sequencer
package ar_pkg;
   typedef enum logic [2:0] {st_idle, st_open, st_dead, st_reclaim, st_final} seq_state_t;
   typedef struct packed {
      logic low_trip;
      logic high_trip;
      logic top_trip;
      logic oc_start;
      logic ef_start;
      logic brk_is_open;
   } stage_in_t;
   typedef struct packed {
      logic [1:0] shots;
      logic [1:0] spare;
      logic inhibit_reclose_on_top_trip;
      logic high_stage_block_shot_three;
      logic high_stage_block_shot_two;
      logic block_later_shots_on_high_trip;
      logic block_first_shot_on_high_trip;
      logic enable;
   } ctrl_t;
endpackage

/* File: rtl/ar_regs.svh */
// Register map, field widths, reset values and timing counts
// Notes on behaviour
// R1: Both switch bits block high stage, shots 2-3
// R2: High-stage blocking starts at shot initiation
// R3: Persistent low-set trips step shots, then final
// R4: Dead expiry issues reclose, starts cutout, reclaim
// R5: Cutout expiry releases blocking before sequence reset
// R6: Low-set overcurrent and earth-fault starts initiate shots
// R7: Each start has own delay; expiry opens breaker
// R8: Start initiation only shot 1 or final
// R9: Start delays default to 300 s
// R10: Start signals always connected, no enable
// R11: Switch bit: high trip blocks shot 1
// R12: Switch bit: high trip blocks shots 2-3
// R13: Switch bit: top trip inhibits all shots
// R14: Shot 1 blocked gives only shots 2-3
// R15: Shots 2-3 blocked gives only shot 1
// R16: Reclaim expiry resets counter, returns idle
// R17: Dead timer starts once breaker has opened
`ifndef AR_REGS_SVH
`define AR_REGS_SVH
`define AR_CLK_HZ 40000000
`define AR_TICK_MS 1
`define AR_TICK_CYC (`AR_CLK_HZ / 1000 * `AR_TICK_MS)
`define AR_START_DELAY_S 300
`define AR_START_DELAY_MS (`AR_START_DELAY_S * 1000)
`define AR_TW 20
`define AR_OFS_CTRL 8'h00
`define AR_OFS_DEAD1 8'h04
`define AR_OFS_DEAD2 8'h08
`define AR_OFS_DEAD3 8'h0C
`define AR_OFS_RECLAIM 8'h10
`define AR_OFS_CUTOUT 8'h14
`define AR_OFS_OC_DELAY 8'h18
`define AR_OFS_EF_DELAY 8'h1C
`define AR_OFS_STATUS 8'h20
`define AR_OFS_IRQ_STAT 8'h24
`define AR_OFS_IRQ_CLR 8'h28
`define AR_OFS_IRQ_EN 8'h2C
`define AR_CTRL_W 10
`define AR_CTRL_RST 10'h0301
`define AR_DEAD_RST 20'h0_01F4
`define AR_RECLAIM_RST 20'h0_2710
`define AR_CUTOUT_RST 20'h0_1388
`define AR_IRQ_W 5
`define AR_SHOT_FINAL 3'h4
`endif

/* File: rtl/auto_reclose_shot_sequencer.sv */
// Auto-reclose shot sequencer with Wishbone register slave
`timescale 1ns/1ps
`include "ar_regs.svh"
module auto_reclose_shot_sequencer #(
   parameter int unsigned TICK_CYCLES = `AR_TICK_CYC
) (
   // Clock and reset
   input wire logic sys_clk,
   input wire logic resetn,
   // Wishbone slave
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   // Protection stages and breaker state
   input wire ar_pkg::stage_in_t stage_in,
   // Breaker commands and stage blocking
   output logic breaker_open_request,
   output logic breaker_close_request,
   output logic high_stage_block,
   output logic irq
);
   localparam logic [15:0] TICK_MAX = 16'(TICK_CYCLES - 1);

   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                         input logic [3:0] sel);
      logic [31:0] r;
      r = old;
      for (int i = 0; i < 4; i++) begin
         if (sel[i]) begin
            r[i*8 +: 8] = nw[i*8 +: 8];
         end
      end
      return r;
   endfunction

   // Shot that a trip would start; final when none remains
   function automatic logic [2:0] pick_shot(input logic [1:0] done, input logic high,
                                            input ar_pkg::ctrl_t c);
      logic [2:0] s;
      s = {1'b0, done} + 3'h1;
      // R11: high trip skips shot 1
      if (s == 3'h1 && high && c.block_first_shot_on_high_trip) begin
         s = 3'h2;
      end
      // R12: high trip bars later shots
      if (s >= 3'h2 && high && c.block_later_shots_on_high_trip) begin
         s = `AR_SHOT_FINAL;
      end
      if (s > {1'b0, c.shots}) begin
         s = `AR_SHOT_FINAL;
      end
      return s;
   endfunction

   // Status word: cutout, blocking, shot and state
   function automatic logic [31:0] status_word(input logic cut, input logic blk,
                                               input logic [1:0] shot,
                                               input ar_pkg::seq_state_t st);
      return {24'h00_0000, cut, blk, shot, 1'b0, st};
   endfunction

   ar_pkg::stage_in_t sync1_r, sync2_r;
   ar_pkg::ctrl_t ctrl_r;
   ar_pkg::seq_state_t state_r, state_nxt;
   logic [`AR_TW-1:0] dead_r [3];
   logic [`AR_TW-1:0] reclaim_r, cutout_r, oc_dly_r, ef_dly_r;
   logic [`AR_TW-1:0] seq_cnt_r, cut_cnt_r, oc_cnt_r, ef_cnt_r;
   logic [15:0] div_r;
   logic tick;
   logic [1:0] shot_r;
   logic [2:0] tgt;
   logic cut_run_r, blk_r, close_r;
   logic [`AR_IRQ_W-1:0] irq_stat_r, irq_en_r, ev;
   logic wb_req, wb_wr, oc_fire, ef_fire, can_init, initiate, inhibit;
   logic dead_done, reclaim_done, cut_done;

   // Pin synchronisers
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         sync1_r <= '0;
         sync2_r <= '0;
      end else begin
         sync1_r <= stage_in;
         sync2_r <= sync1_r;
      end
   end

   // Millisecond tick divider
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         div_r <= '0;
      end else if (div_r == TICK_MAX) begin
         div_r <= '0;
      end else begin
         div_r <= div_r + 16'h0001;
      end
   end
   assign tick = (div_r == TICK_MAX);

   assign wb_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
   // Writes land on the acknowledged edge, as the master samples ack
   assign wb_wr = wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o;

   // Setting registers
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         ctrl_r <= ar_pkg::ctrl_t'(`AR_CTRL_RST);
         for (int i = 0; i < 3; i++) begin
            dead_r[i] <= `AR_DEAD_RST;
         end
         reclaim_r <= `AR_RECLAIM_RST;
         cutout_r <= `AR_CUTOUT_RST;
         // R9: start delays default 300 s
         oc_dly_r <= `AR_TW'(`AR_START_DELAY_MS);
         ef_dly_r <= `AR_TW'(`AR_START_DELAY_MS);
         irq_en_r <= '0;
      end else if (wb_wr) begin
         case (wb_adr_i)
            `AR_OFS_CTRL: begin
               ctrl_r <= ar_pkg::ctrl_t'(merge(32'(ctrl_r), wb_dat_i, wb_sel_i));
            end
            `AR_OFS_DEAD1: begin
               dead_r[0] <= `AR_TW'(merge(32'(dead_r[0]), wb_dat_i, wb_sel_i));
            end
            `AR_OFS_DEAD2: begin
               dead_r[1] <= `AR_TW'(merge(32'(dead_r[1]), wb_dat_i, wb_sel_i));
            end
            `AR_OFS_DEAD3: begin
               dead_r[2] <= `AR_TW'(merge(32'(dead_r[2]), wb_dat_i, wb_sel_i));
            end
            `AR_OFS_RECLAIM: begin
               reclaim_r <= `AR_TW'(merge(32'(reclaim_r), wb_dat_i, wb_sel_i));
            end
            `AR_OFS_CUTOUT: begin
               cutout_r <= `AR_TW'(merge(32'(cutout_r), wb_dat_i, wb_sel_i));
            end
            `AR_OFS_OC_DELAY: begin
               oc_dly_r <= `AR_TW'(merge(32'(oc_dly_r), wb_dat_i, wb_sel_i));
            end
            `AR_OFS_EF_DELAY: begin
               ef_dly_r <= `AR_TW'(merge(32'(ef_dly_r), wb_dat_i, wb_sel_i));
            end
            `AR_OFS_IRQ_EN: begin
               irq_en_r <= `AR_IRQ_W'(merge(32'(irq_en_r), wb_dat_i, wb_sel_i));
            end
            default: begin
            end
         endcase
      end
   end

   // R10: start delays always armed
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         oc_cnt_r <= '0;
         ef_cnt_r <= '0;
      end else begin
         // R7: separate start delays
         if (!sync2_r.oc_start || initiate) begin
            oc_cnt_r <= '0;
         end else if (tick && oc_cnt_r < oc_dly_r) begin
            oc_cnt_r <= oc_cnt_r + `AR_TW'(1);
         end
         if (!sync2_r.ef_start || initiate) begin
            ef_cnt_r <= '0;
         end else if (tick && ef_cnt_r < ef_dly_r) begin
            ef_cnt_r <= ef_cnt_r + `AR_TW'(1);
         end
      end
   end

   // R6: both low-set starts initiate
   assign oc_fire = sync2_r.oc_start && oc_cnt_r >= oc_dly_r;
   assign ef_fire = sync2_r.ef_start && ef_cnt_r >= ef_dly_r;

   assign tgt = pick_shot(shot_r, sync2_r.high_trip, ctrl_r);
   assign can_init = ctrl_r.enable && (state_r == ar_pkg::st_idle ||
                                       state_r == ar_pkg::st_reclaim);
   // R13: top trip inhibits reclosing
   assign inhibit = can_init && ctrl_r.inhibit_reclose_on_top_trip && sync2_r.top_trip;
   // R3: trips step the sequence
   // R8: starts only for shot 1 or final
   assign initiate = can_init && (sync2_r.low_trip || sync2_r.high_trip ||
                     ((oc_fire || ef_fire) && (tgt == 3'h1 || tgt == `AR_SHOT_FINAL)));

   assign dead_done = state_r == ar_pkg::st_dead && seq_cnt_r >= dead_r[shot_r - 2'h1];
   assign reclaim_done = state_r == ar_pkg::st_reclaim && seq_cnt_r >= reclaim_r;
   assign cut_done = cut_run_r && cut_cnt_r >= cutout_r;

   always_comb begin
      state_nxt = state_r;
      case (state_r)
         ar_pkg::st_idle, ar_pkg::st_reclaim: begin
            if (inhibit || (initiate && tgt == `AR_SHOT_FINAL)) begin
               state_nxt = ar_pkg::st_final;
            end else if (initiate) begin
               state_nxt = ar_pkg::st_open;
            // R16: reclaim expiry ends sequence
            end else if (reclaim_done) begin
               state_nxt = ar_pkg::st_idle;
            end
         end
         ar_pkg::st_open: begin
            // R17: dead time after breaker opens
            if (sync2_r.brk_is_open) begin
               state_nxt = ar_pkg::st_dead;
            end
         end
         ar_pkg::st_dead: begin
            if (dead_done) begin
               state_nxt = ar_pkg::st_reclaim;
            end
         end
         ar_pkg::st_final: begin
            if (!sync2_r.brk_is_open && !breaker_open_request) begin
               state_nxt = ar_pkg::st_idle;
            end
         end
         default: state_nxt = ar_pkg::st_idle;
      endcase
   end

   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         state_r <= ar_pkg::st_idle;
      end else begin
         state_r <= state_nxt;
      end
   end

   // Shot counter
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         shot_r <= '0;
      end else if (state_nxt == ar_pkg::st_idle) begin
         shot_r <= '0;
      end else if (initiate && state_nxt == ar_pkg::st_open) begin
         // R14: skipped shot 1 leads to 2
         // R15: barred later shots end sequence
         shot_r <= tgt[1:0];
      end
   end

   // Dead and reclaim timer
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         seq_cnt_r <= '0;
      end else if (state_nxt != state_r) begin
         seq_cnt_r <= '0;
      end else if (tick && seq_cnt_r != '1) begin
         seq_cnt_r <= seq_cnt_r + `AR_TW'(1);
      end
   end

   // R4: reclose starts cutout and reclaim
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         cut_run_r <= 1'b0;
         cut_cnt_r <= '0;
         close_r <= 1'b0;
      end else begin
         close_r <= dead_done;
         if (dead_done) begin
            cut_run_r <= 1'b1;
            cut_cnt_r <= '0;
         end else if (cut_done || state_r != ar_pkg::st_reclaim) begin
            cut_run_r <= 1'b0;
         end else if (tick) begin
            cut_cnt_r <= cut_cnt_r + `AR_TW'(1);
         end
      end
   end

   // High-stage blocking
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         blk_r <= 1'b0;
      end else if (initiate && state_nxt == ar_pkg::st_open) begin
         // R1: block high stage for shots 2, 3
         // R2: blocking set at initiation
         blk_r <= (tgt == 3'h2 && ctrl_r.high_stage_block_shot_two) ||
                  (tgt == 3'h3 && ctrl_r.high_stage_block_shot_three);
      // R5: cutout releases blocking early
      end else if (cut_done || state_nxt == ar_pkg::st_idle || state_nxt == ar_pkg::st_final) begin
         blk_r <= 1'b0;
      end
   end

   // R7: open command on initiation
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         breaker_open_request <= 1'b0;
      end else begin
         breaker_open_request <= (state_nxt == ar_pkg::st_open ||
                                  state_nxt == ar_pkg::st_final) &&
                                 !sync2_r.brk_is_open;
      end
   end

   assign breaker_close_request = close_r;
   assign high_stage_block = blk_r;

   // Events: shot, reclose, final, reset, inhibit
   assign ev = {inhibit,
                reclaim_done && state_nxt == ar_pkg::st_idle,
                state_nxt == ar_pkg::st_final && state_r != ar_pkg::st_final,
                dead_done,
                initiate && state_nxt == ar_pkg::st_open};

   // Sticky status; a new event beats the clear
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         irq_stat_r <= '0;
      end else if (wb_wr && wb_adr_i == `AR_OFS_IRQ_CLR && wb_sel_i[0]) begin
         irq_stat_r <= (irq_stat_r & ~wb_dat_i[`AR_IRQ_W-1:0]) | ev;
      end else begin
         irq_stat_r <= irq_stat_r | ev;
      end
   end
   assign irq = |(irq_stat_r & irq_en_r);

   // Read path and acknowledge
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= '0;
      end else begin
         wb_ack_o <= wb_req;
         if (wb_req && !wb_we_i) begin
            case (wb_adr_i)
               `AR_OFS_CTRL: begin
                  wb_dat_o <= 32'(ctrl_r);
               end
               `AR_OFS_DEAD1: begin
                  wb_dat_o <= 32'(dead_r[0]);
               end
               `AR_OFS_DEAD2: begin
                  wb_dat_o <= 32'(dead_r[1]);
               end
               `AR_OFS_DEAD3: begin
                  wb_dat_o <= 32'(dead_r[2]);
               end
               `AR_OFS_RECLAIM: begin
                  wb_dat_o <= 32'(reclaim_r);
               end
               `AR_OFS_CUTOUT: begin
                  wb_dat_o <= 32'(cutout_r);
               end
               `AR_OFS_OC_DELAY: begin
                  wb_dat_o <= 32'(oc_dly_r);
               end
               `AR_OFS_EF_DELAY: begin
                  wb_dat_o <= 32'(ef_dly_r);
               end
               `AR_OFS_STATUS: begin
                  wb_dat_o <= status_word(cut_run_r, blk_r, shot_r, state_r);
               end
               `AR_OFS_IRQ_STAT: begin
                  wb_dat_o <= 32'(irq_stat_r);
               end
               `AR_OFS_IRQ_EN: begin
                  wb_dat_o <= 32'(irq_en_r);
               end
               default: wb_dat_o <= '0;
            endcase
         end
      end
   end
endmodule // auto_reclose_shot_sequencer

/* File: test/ar_sva.sv */
// Port checker for the auto-reclose sequencer
`timescale 1ns/1ps
module ar_sva #(
   parameter int unsigned TICK_CYCLES = 4
) (
   // Clock, reset and bus
   input wire logic sys_clk,
   input wire logic resetn,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   input wire logic [31:0] wb_dat_o,
   input wire logic wb_ack_o,
   // Stages and commands
   input wire ar_pkg::stage_in_t stage_in,
   input wire logic breaker_open_request,
   input wire logic breaker_close_request,
   input wire logic high_stage_block,
   input wire logic irq
);
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!resetn);
   sequence req_s;
      wb_cyc_i && wb_stb_i && !wb_ack_o;
   endsequence
   sequence open_rise_s;
      $rose(breaker_open_request);
   endsequence
   bus_answer_a: assert property (req_s |=> wb_ack_o)
      else $error("bus request not answered");
   ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack longer than one cycle");
   close_pulse_a: assert property (breaker_close_request |=> !breaker_close_request)
      else $error("close command not a pulse");
   cmd_exclusive_a: assert property (!(breaker_open_request && breaker_close_request))
      else $error("open and close together");
   open_hold_a: assert property (breaker_open_request &&
                                 !stage_in.brk_is_open |=> breaker_open_request)
      else $error("open request dropped early");
   open_cause_a: assert property (open_rise_s |-> $past(|stage_in[5:1], 3))
      else $error("open request without cause");
   close_after_open_a: assert property (breaker_close_request |->
                                        $past(stage_in.brk_is_open, 2))
      else $error("reclose with breaker closed");
   block_at_shot_a: assert property ($rose(high_stage_block) |->
                                     breaker_open_request || $past(breaker_open_request))
      else $error("blocking outside initiation");
endmodule // ar_sva
bind auto_reclose_shot_sequencer ar_sva #(.TICK_CYCLES(TICK_CYCLES)) ar_sva_inst (
   .sys_clk(sys_clk), .resetn(resetn), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
   .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
   .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .stage_in(stage_in),
   .breaker_open_request(breaker_open_request), .breaker_close_request(breaker_close_request),
   .high_stage_block(high_stage_block), .irq(irq));

/* File: test/auto_reclose_shot_sequencer_tb.sv */
// Self-checking bench for the auto-reclose sequencer
`timescale 1ns/1ps
module auto_reclose_shot_sequencer_tb;
   logic sys_clk = 1'b0;
   logic resetn = 1'b0;
   logic cyc = 1'b0;
   logic stb = 1'b0;
   logic we = 1'b0;
   logic man_cl = 1'b0;
   logic [7:0] adr = 8'h00;
   logic [31:0] dat = 32'h0000_0000;
   logic [4:0] trips = 5'h00;
   logic brk, ack, opn, cls, blk, irq;
   logic [31:0] dat_o, q;
   int bad_count = 0;
   int total_checks = 0;
   ar_pkg::stage_in_t sin;
   assign sin = {trips, brk};
   auto_reclose_shot_sequencer #(.TICK_CYCLES(4)) auto_reclose_shot_sequencer_inst (
      .sys_clk(sys_clk), .resetn(resetn), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
      .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(dat), .wb_dat_o(dat_o), .wb_ack_o(ack),
      .stage_in(sin), .breaker_open_request(opn), .breaker_close_request(cls),
      .high_stage_block(blk), .irq(irq));
   breaker_model breaker_model_inst (.sys_clk(sys_clk), .resetn(resetn), .open_cmd(opn),
      .close_cmd(cls), .manual_close(man_cl), .brk_is_open(brk));
   initial begin
      forever #12.5 sys_clk = ~sys_clk;
   end
   task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
      total_checks++;
      if (s !== e) begin
         bad_count++;
         $display("MISMATCH %s expected %h seen %h", n, e, s);
      end
   endtask
   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge sys_clk);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      dat <= d;
      do begin
         @(posedge sys_clk);
         n++;
      end while (ack !== 1'b1);
      q = dat_o;
      cyc <= 1'b0;
      stb <= 1'b0;
      chk("ack wait", n, 2);
   endtask
   task automatic rd(input logic [7:0] a, input string n, input logic [31:0] e);
      wb(1'b0, a, 32'h0000_0000);
      chk(n, q, e);
   endtask
   task automatic st(input logic [2:0] s, input logic [1:0] sh);
      wb(1'b0, 8'h20, 32'h0000_0000);
      chk("state", q[2:0], s);
      chk("shot", q[5:4], sh);
   endtask
   task automatic wt(input bit c);
      int n;
      n = 0;
      while ((c ? cls : opn) !== 1'b1 && n < 300) begin
         @(posedge sys_clk);
         n++;
      end
      chk(c ? "close" : "open", n < 300, 1);
   endtask
   task automatic trip(input int i);
      @(posedge sys_clk);
      trips[i] <= 1'b1;
      repeat (4) @(posedge sys_clk);
      trips[i] <= 1'b0;
   endtask
   task automatic mc();
      @(posedge sys_clk);
      man_cl <= 1'b1;
      @(posedge sys_clk);
      man_cl <= 1'b0;
      repeat (10) @(posedge sys_clk);
   endtask
   task automatic regs_test();
      rd(8'h00, "ctrl", 32'h0000_0301);
      rd(8'h04, "dead", 32'h0000_01F4);
      rd(8'h10, "reclaim", 32'h0000_2710);
      rd(8'h14, "cutout", 32'h0000_1388);
      rd(8'h18, "oc delay", 32'h0004_93E0);
      rd(8'h1C, "ef delay", 32'h0004_93E0);
      rd(8'h30, "unmapped", 32'h0000_0000);
      for (int a = 4; a <= 12; a += 4) wb(1'b1, a[7:0], 32'h0000_0002);
      wb(1'b1, 8'h10, 32'h0000_0014);
      wb(1'b1, 8'h14, 32'h0000_0008);
      wb(1'b1, 8'h18, 32'h0000_0005);
      wb(1'b1, 8'h1C, 32'h0000_0005);
      wb(1'b1, 8'h2C, 32'h0000_0002);
   endtask
   task automatic seq_test();
      trip(4);
      wt(1'b1);
      st(3'h3, 2'h1);
      chk("irq set", irq, 1);
      wb(1'b1, 8'h28, 32'h0000_0002);
      @(posedge sys_clk);
      chk("irq clear", irq, 0);
      repeat (100) @(posedge sys_clk);
      st(3'h0, 2'h0);
      wb(1'b1, 8'h2C, 32'h0000_0000);
      trip(4);
      wt(1'b1);
      trip(4);
      wt(1'b1);
      st(3'h3, 2'h2);
      chk("irq masked", irq, 0);
      trip(4);
      wt(1'b1);
      st(3'h3, 2'h3);
      trip(4);
      repeat (30) @(posedge sys_clk);
      st(3'h4, 2'h3);
      mc();
      st(3'h0, 2'h0);
   endtask
   task automatic blk_test();
      wb(1'b1, 8'h00, 32'h0000_031B);
      trip(3);
      wt(1'b0);
      chk("block on", blk, 1);
      wt(1'b1);
      st(3'h3, 2'h2);
      repeat (45) @(posedge sys_clk);
      chk("block off", blk, 0);
      st(3'h3, 2'h2);
      repeat (60) @(posedge sys_clk);
   endtask
   task automatic later_test();
      wb(1'b1, 8'h00, 32'h0000_0305);
      trip(3);
      wt(1'b1);
      st(3'h3, 2'h1);
      trip(3);
      repeat (20) @(posedge sys_clk);
      st(3'h4, 2'h1);
      mc();
      wb(1'b1, 8'h00, 32'h0000_0325);
      trip(2);
      repeat (20) @(posedge sys_clk);
      st(3'h4, 2'h0);
      wb(1'b0, 8'h24, 32'h0000_0000);
      chk("inhibit", q[4], 1);
      mc();
      wb(1'b1, 8'h00, 32'h0000_0300);
      trip(4);
      repeat (10) @(posedge sys_clk);
      chk("disabled", opn, 0);
      st(3'h0, 2'h0);
   endtask
   task automatic start_test();
      int n;
      wb(1'b1, 8'h00, 32'h0000_0301);
      for (int i = 0; i < 2; i++) begin
         n = 0;
         @(posedge sys_clk);
         trips[1 - i] <= 1'b1;
         while (opn !== 1'b1 && n < 100) begin
            @(posedge sys_clk);
            n++;
         end
         chk("start delay", n >= 18 && n <= 30, 1);
         trips <= 5'h00;
         wt(1'b1);
         st(3'h3, 2'h1);
         trips[1 - i] <= 1'b1;
         repeat (40) @(posedge sys_clk);
         chk("later start", opn, 0);
         trips <= 5'h00;
         repeat (100) @(posedge sys_clk);
      end
      wb(1'b1, 8'h00, 32'h0000_0001);
      trips[1] <= 1'b1;
      wt(1'b0);
      repeat (10) @(posedge sys_clk);
      st(3'h4, 2'h0);
      trips <= 5'h00;
      mc();
      st(3'h0, 2'h0);
   endtask
   task automatic give_verdict();
      $display("checks %0d mismatches %0d", total_checks, bad_count);
      if (bad_count == 0 && total_checks > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask
   initial begin
      #(25 * 20000);
      bad_count++;
      give_verdict();
   end
   initial begin
      repeat (8) @(posedge sys_clk);
      resetn <= 1'b1;
      regs_test();
      seq_test();
      blk_test();
      later_test();
      start_test();
      give_verdict();
   end
endmodule // auto_reclose_shot_sequencer_tb

/* File: test/breaker_model.sv */
// Circuit breaker model following open and close commands
`timescale 1ns/1ps
module breaker_model #(
   parameter int OPEN_CYC = 3
) (
   // Clock and reset
   input wire logic sys_clk,
   input wire logic resetn,
   // Commands
   input wire logic open_cmd,
   input wire logic close_cmd,
   input wire logic manual_close,
   // Contact state
   output logic brk_is_open
);
   int cnt;
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         cnt <= 0;
         brk_is_open <= 1'b0;
      end else if (close_cmd || manual_close) begin
         cnt <= 0;
         brk_is_open <= 1'b0;
      end else if (open_cmd && !brk_is_open) begin
         // Mechanism takes a few cycles to part
         if (cnt == OPEN_CYC) brk_is_open <= 1'b1;
         else cnt <= cnt + 1;
      end else cnt <= 0;
   end
endmodule // breaker_model
